// >>> rtl/cli_divider.sv
`timescale 1ns/10ps
`default_nettype none
`include "cli_params.svh"
module cli_divider
  import cli_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // Request
  input  wire logic        start_in,
  input  wire logic [31:0] dividend_in,
  input  wire logic [31:0] divisor_in,
  // Result
  output logic             done_out,
  output logic [31:0]      quot_out,
  output logic [31:0]      rem_out
);
  // Signed restoring division, truncating toward zero, one bit a cycle
  logic [31:0] num_q;
  logic [31:0] den_q;
  logic [31:0] rem_q;
  logic [31:0] quo_q;
  logic [5:0]  cnt_q;
  logic        busy_q;
  logic        qneg_q;
  logic        rneg_q;
  wire  [31:0] a_abs   = dividend_in[31] ? 32'(-dividend_in) : dividend_in;
  wire  [31:0] b_abs   = divisor_in[31] ? 32'(-divisor_in) : divisor_in;
  wire  [32:0] shifted = {rem_q, num_q[31]};
  wire  [32:0] trial   = shifted - {1'b0, den_q};
  wire         fits    = ~trial[32];
  wire         last    = busy_q && (cnt_q == 6'h01);

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      num_q  <= 32'h0000_0000;
      den_q  <= 32'h0000_0000;
      rem_q  <= 32'h0000_0000;
      quo_q  <= 32'h0000_0000;
      cnt_q  <= 6'h00;
      busy_q <= 1'b0;
      qneg_q <= 1'b0;
      rneg_q <= 1'b0;
    end
    else if (start_in)
    begin
      num_q  <= a_abs;
      den_q  <= b_abs;
      rem_q  <= 32'h0000_0000;
      quo_q  <= 32'h0000_0000;
      cnt_q  <= `CLI_DIV_STEPS;
      busy_q <= 1'b1;
      qneg_q <= dividend_in[31] ^ divisor_in[31];
      rneg_q <= dividend_in[31];
    end
    else if (busy_q)
    begin
      rem_q  <= fits ? trial[31:0] : shifted[31:0];
      quo_q  <= {quo_q[30:0], fits};
      num_q  <= {num_q[30:0], 1'b0};
      cnt_q  <= cnt_q - 6'h01;
      busy_q <= ~last;
    end
  end

  // Result valid the cycle after the last step
  logic done_q;
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      done_q <= 1'b0;
    else
      done_q <= last;
  end
  assign done_out = done_q;
  assign quot_out = qneg_q ? 32'(-quo_q) : quo_q;
  assign rem_out  = rneg_q ? 32'(-rem_q) : rem_q;
endmodule : cli_divider
`default_nettype wire

// >>> rtl/cli_params.svh
`ifndef CLI_PARAMS_SVH
`define CLI_PARAMS_SVH
`define CLI_OPC_XREG_CALC   8'h2C
`define CLI_OPC_VAR_CALC    8'h2D
`define CLI_OPC_RESTART     8'h30
`define CLI_OPC_DECREMENT_BRANCH_NONZERO_OP        8'h31
`define CLI_TYPE_ADD        8'h00
`define CLI_TYPE_SUB        8'h01
`define CLI_TYPE_MUL        8'h02
`define CLI_TYPE_DIV        8'h03
`define CLI_TYPE_MOD        8'h04
`define CLI_TYPE_AND        8'h05
`define CLI_TYPE_OR         8'h06
`define CLI_TYPE_XOR        8'h07
`define CLI_TYPE_NOT        8'h08
`define CLI_TYPE_LOAD       8'h09
`define CLI_TYPE_SWAP       8'h0A
`define CLI_TYPE_COMP       8'h0B
`define CLI_STATUS_OK       8'h64
`define CLI_STATUS_BAD_CMD  8'h02
`define CLI_STATUS_BAD_TYPE 8'h03
`define CLI_STATUS_BAD_SUM  8'h01
`define CLI_HOST_ADDR       8'h02
`define CLI_MODULE_ADDR     8'h01
`define CLI_FRAME_LEN       4'h9
`define CLI_DIV_STEPS       6'h20
`define CLI_PC_RESET        32'h0000_0000
`endif

// >>> rtl/cli_pkg.sv
package cli_pkg;
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  opcode;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] value;
  } cli_cmd_t;

  typedef struct packed {
    logic zero;
    logic equal;
    logic greater;
    logic lower;
  } cli_flags_t;

  typedef enum logic [2:0] {
    CLI_IDLE  = 3'b000,
    CLI_READ  = 3'b001,
    CLI_EXEC  = 3'b010,
    CLI_DIV   = 3'b011,
    CLI_WRITE = 3'b100,
    CLI_REPLY = 3'b101
  } cli_state_t;
endpackage : cli_pkg

// >>> rtl/cli_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "cli_params.svh"
module cli_unit
  import cli_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // Command byte stream
  input  wire logic        cmd_valid_in,
  input  wire logic [7:0]  cmd_byte_in,
  output logic             cmd_ready_out,
  // Reply byte stream
  output logic             rsp_valid_out,
  output logic [7:0]       rsp_byte_out,
  input  wire logic        rsp_ready_in,
  // Program sequencer side
  input  wire logic        standalone_in,
  input  wire logic [31:0] pc_next_in,
  output logic             pc_load_out,
  output logic [31:0]      pc_value_out,
  output logic             interp_reset_out,
  // Working registers and flags
  output logic [31:0]      xreg_out,
  output cli_flags_t       flags_out
);
  cli_state_t  state_q;
  cli_cmd_t    cmd_q;
  logic [3:0]  rx_cnt_q;
  logic [7:0]  rx_sum_q;
  logic        sum_ok_q;
  logic [31:0] var_mem [256];
  logic [31:0] var_q;
  logic [31:0] xreg_q;
  logic [31:0] result_q;
  logic        wr_var_q;
  logic [7:0]  status_q;
  logic [71:0] tx_q;
  logic [3:0]  tx_cnt_q;
  logic [7:0]  tx_sum_q;
  logic        div_start_q;
  logic        div_wait_q;
  logic [5:0]  div_cnt_q;
  cli_flags_t  flags_q;
  logic        pc_load_q;
  logic [31:0] pc_value_q;
  logic        ireset_q;
  logic [31:0] quot;
  logic [31:0] rem;

  // Command framing
  wire        rx_take   = cmd_valid_in && cmd_ready_out;
  wire        rx_last   = rx_take && (rx_cnt_q == `CLI_FRAME_LEN - 4'h1);
  wire        sum_match = (rx_sum_q == cmd_byte_in);
  wire        is_xcalc  = (cmd_q.opcode == `CLI_OPC_XREG_CALC);
  wire        is_vcalc  = (cmd_q.opcode == `CLI_OPC_VAR_CALC);
  wire        is_rst    = (cmd_q.opcode == `CLI_OPC_RESTART);
  wire        is_decrement_branch_nonzero_op   = (cmd_q.opcode == `CLI_OPC_DECREMENT_BRANCH_NONZERO_OP);
  wire [7:0]  var_index = is_decrement_branch_nonzero_op ? cmd_q.typ : cmd_q.bank;
  wire [31:0] operand   = is_vcalc ? cmd_q.value : var_q;
  wire [31:0] lhs       = is_vcalc ? var_q : xreg_q;
  wire        type_ok   = is_xcalc ? (cmd_q.typ <= `CLI_TYPE_COMP)
                                   : (cmd_q.typ <= `CLI_TYPE_COMP
                                      && cmd_q.typ != `CLI_TYPE_SWAP);
  wire        is_div    = (cmd_q.typ == `CLI_TYPE_DIV) || (cmd_q.typ == `CLI_TYPE_MOD);
  wire [31:0] dec_val   = var_q - 32'h0000_0001;
  wire [31:0] prod      = 32'(lhs * operand);
  wire        div_zero  = (operand == 32'h0000_0000);

  assign cmd_ready_out = (state_q == CLI_IDLE);
  assign rsp_valid_out = (state_q == CLI_REPLY);
  // Status is muxed in late so a host that is ready at once still sees it
  assign rsp_byte_out  = (tx_cnt_q == 4'h8) ? tx_sum_q :
                         (tx_cnt_q == 4'h2) ? status_q : tx_q[71:64];

  // Arithmetic selection
  logic [31:0] alu;
  always_comb
  begin
    case (cmd_q.typ)
      `CLI_TYPE_ADD:  alu = lhs + operand;
      `CLI_TYPE_SUB:  alu = lhs - operand;
      `CLI_TYPE_MUL:  alu = prod;
      `CLI_TYPE_DIV:  alu = div_zero ? lhs : quot;
      `CLI_TYPE_MOD:  alu = div_zero ? lhs : rem;
      `CLI_TYPE_AND:  alu = lhs & operand;
      `CLI_TYPE_OR:   alu = lhs | operand;
      `CLI_TYPE_XOR:  alu = lhs ^ operand;
      `CLI_TYPE_NOT:  alu = is_vcalc ? ~var_q : ~var_q;
      `CLI_TYPE_LOAD: alu = operand;
      `CLI_TYPE_SWAP: alu = var_q;
      default:        alu = lhs;
    endcase
  end

  cli_divider u_div (
    .clk_sys_in  (clk_sys_in),
    .rst_in      (rst_in),
    .start_in    (div_start_q),
    .dividend_in (lhs),
    .divisor_in  (operand),
    .done_out    (),
    .quot_out    (quot),
    .rem_out     (rem)
  );

  // User-variable store; divide by zero leaves the target unchanged
  always_ff @(posedge clk_sys_in)
  begin
    if (wr_var_q)
      var_mem[var_index] <= result_q;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q     <= CLI_IDLE;
      cmd_q       <= '0;
      rx_cnt_q    <= 4'h0;
      rx_sum_q    <= 8'h00;
      sum_ok_q    <= 1'b0;
      var_q       <= 32'h0000_0000;
      xreg_q      <= 32'h0000_0000;
      result_q    <= 32'h0000_0000;
      wr_var_q    <= 1'b0;
      status_q    <= 8'h00;
      tx_q        <= '0;
      tx_cnt_q    <= 4'h0;
      tx_sum_q    <= 8'h00;
      div_start_q <= 1'b0;
      div_wait_q  <= 1'b0;
      div_cnt_q   <= 6'h00;
      flags_q     <= '0;
      pc_load_q   <= 1'b0;
      pc_value_q  <= `CLI_PC_RESET;
      ireset_q    <= 1'b0;
    end
    else
    begin
      pc_load_q   <= 1'b0;
      ireset_q    <= 1'b0;
      wr_var_q    <= 1'b0;
      div_start_q <= 1'b0;
      case (state_q)
        CLI_IDLE:
        begin
          if (rx_take)
          begin
            rx_cnt_q <= rx_last ? 4'h0 : rx_cnt_q + 4'h1;
            rx_sum_q <= rx_last ? 8'h00 : 8'(rx_sum_q + cmd_byte_in);
            if (!rx_last)
              cmd_q <= {cmd_q[55:0], cmd_byte_in};
            else
            begin
              sum_ok_q <= sum_match;
              state_q  <= CLI_READ;
            end
          end
        end
        CLI_READ:
        begin
          var_q   <= var_mem[var_index];
          state_q <= CLI_EXEC;
        end
        CLI_EXEC:
        begin
          status_q <= `CLI_STATUS_OK;
          state_q  <= CLI_REPLY;
          if (!sum_ok_q)
            status_q <= `CLI_STATUS_BAD_SUM;
          else if ((is_xcalc || is_vcalc) && !type_ok)
            status_q <= `CLI_STATUS_BAD_TYPE;
          else if ((is_xcalc || is_vcalc) && is_div && !div_wait_q)
          begin
            div_start_q <= 1'b1;
            div_wait_q  <= 1'b1;
            div_cnt_q   <= `CLI_DIV_STEPS + 6'h01;
            state_q     <= CLI_DIV;
          end
          else if (is_xcalc || is_vcalc)
          begin
            div_wait_q <= 1'b0;
            if (cmd_q.typ == `CLI_TYPE_COMP)
            begin
              flags_q.zero    <= (lhs - operand) == 32'h0000_0000;
              flags_q.equal   <= lhs == operand;
              flags_q.greater <= $signed(lhs) > $signed(operand);
              flags_q.lower   <= $signed(lhs) < $signed(operand);
            end
            else
            begin
              // Assignment compares the result with zero, keeping flags consistent
              flags_q.zero    <= alu == 32'h0000_0000;
              flags_q.equal   <= alu == 32'h0000_0000;
              flags_q.greater <= !alu[31] && (alu != 32'h0000_0000);
              flags_q.lower   <= alu[31];
              result_q      <= is_vcalc ? alu : xreg_q;
              wr_var_q      <= is_vcalc || (cmd_q.typ == `CLI_TYPE_SWAP);
              if (is_xcalc)
                xreg_q <= alu;
              if (is_vcalc || (cmd_q.typ == `CLI_TYPE_SWAP))
                state_q <= CLI_WRITE;
            end
          end
          else if (is_rst && standalone_in)
          begin
            ireset_q   <= 1'b1;
            xreg_q     <= 32'h0000_0000;
            flags_q    <= '0;
            pc_load_q  <= 1'b1;
            pc_value_q <= cmd_q.value;
          end
          else if (is_decrement_branch_nonzero_op && standalone_in)
          begin
            result_q   <= dec_val;
            state_q    <= CLI_WRITE;
            pc_load_q  <= 1'b1;
            pc_value_q <= (dec_val != 32'h0000_0000) ? cmd_q.value : pc_next_in;
          end
          else
            status_q <= `CLI_STATUS_BAD_CMD;
          tx_q <= {`CLI_HOST_ADDR, `CLI_MODULE_ADDR, 8'h00, cmd_q.opcode,
                   is_xcalc ? var_q : cmd_q.value, 8'h00};
        end
        CLI_DIV:
        begin
          div_cnt_q <= div_cnt_q - 6'h01;
          if (div_cnt_q == 6'h01)
            state_q <= CLI_EXEC;
        end
        CLI_WRITE:
        begin
          wr_var_q <= 1'b1;
          state_q  <= CLI_REPLY;
        end
        CLI_REPLY:
        begin
          if (rsp_ready_in)
          begin
            tx_sum_q <= 8'(tx_sum_q + rsp_byte_out);
            tx_q     <= {tx_q[63:0], 8'h00};
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q == 4'h8)
            begin
              tx_cnt_q <= 4'h0;
              tx_sum_q <= 8'h00;
              state_q  <= CLI_IDLE;
            end
          end
        end
        default: state_q <= CLI_IDLE;
      endcase
    end
  end

  assign pc_load_out      = pc_load_q;
  assign pc_value_out     = pc_value_q;
  assign interp_reset_out = ireset_q;
  assign xreg_out         = xreg_q;
  assign flags_out        = flags_q;
endmodule : cli_unit
`default_nettype wire

// >>> verif/calc_and_loop_instruction_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module calc_and_loop_instruction_unit_tb;
  import cli_pkg::*;
  logic        clk_sys_in    = 1'b0;
  logic        rst_in        = 1'b1;
  logic        standalone_in = 1'b0;
  logic [31:0] pc_next_in    = 32'h55;
  logic        cmd_valid_in, cmd_ready_out, rsp_valid_out, rsp_ready_in;
  logic        pc_load_out, interp_reset_out;
  logic [7:0]  cmd_byte_in, rsp_byte_out;
  logic [31:0] pc_value_out, xreg_out, last_pc, rval;
  cli_flags_t  flags_out;
  int          failures, n_tests, n_load, n_rst, cycles;

  cli_unit i_cli_unit (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .cmd_valid_in(cmd_valid_in), .cmd_byte_in(cmd_byte_in), .cmd_ready_out(cmd_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_byte_out(rsp_byte_out), .rsp_ready_in(rsp_ready_in),
    .standalone_in(standalone_in), .pc_next_in(pc_next_in), .pc_load_out(pc_load_out),
    .pc_value_out(pc_value_out), .interp_reset_out(interp_reset_out),
    .xreg_out(xreg_out), .flags_out(flags_out));
  cli_host_model i_cli_host_model (.clk_sys_in(clk_sys_in), .cmd_valid_out(cmd_valid_in),
    .cmd_byte_out(cmd_byte_in), .ready_in(cmd_ready_out), .rsp_valid_in(rsp_valid_out),
    .rsp_byte_in(rsp_byte_out), .rsp_ready_out(rsp_ready_in));
  assign rval = {i_cli_host_model.rsp_q[4], i_cli_host_model.rsp_q[5],
                 i_cli_host_model.rsp_q[6], i_cli_host_model.rsp_q[7]};

  initial forever #2 clk_sys_in = ~clk_sys_in;

  always @(negedge clk_sys_in)
  begin
    if (pc_load_out === 1'b1)
    begin
      n_load++;
      last_pc = pc_value_out;
    end
    if (interp_reset_out === 1'b1) n_rst++;
  end

  task automatic give_verdict;
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      failures++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic run(input logic [7:0] op, typ, bank, input logic [31:0] val,
                     input logic [7:0] st, input logic bad = 1'b0);
    logic [7:0] s;
    i_cli_host_model.frame(op, typ, bank, val, bad);
    s = 8'h00;
    for (int i = 0; i < 8; i++) s += i_cli_host_model.rsp_q[i];
    check("status", {24'h0, i_cli_host_model.rsp_q[2]}, {24'h0, st});
    check("header", {8'h0, i_cli_host_model.rsp_q[0], i_cli_host_model.rsp_q[1],
      i_cli_host_model.rsp_q[3]}, {8'h0, 8'h02, 8'h01, op});
    check("checksum", {24'h0, i_cli_host_model.rsp_q[8]}, {24'h0, s});
  endtask : run

  task automatic t_var_imm;
    run(8'h2D, 8'h09, 8'h1B, 32'h1388, 8'h64);
    check("reply value", rval, 32'h1388);
    run(8'h2C, 8'h09, 8'h1B, 32'h0, 8'h64);
    check("x copy", xreg_out, 32'h1388);
    run(8'h2D, 8'h01, 8'h1B, 32'h1389, 8'h64);
    run(8'h2C, 8'h09, 8'h1B, 32'h0, 8'h64);
    check("var minus imm", xreg_out, 32'hFFFF_FFFF);
    run(8'h2D, 8'h08, 8'h1B, 32'h1234, 8'h64);
    run(8'h2C, 8'h09, 8'h1B, 32'h0, 8'h64);
    check("var inverted", xreg_out, 32'h0);
    run(8'h2D, 8'h0A, 8'h1B, 32'h0, 8'h03);
    // A corrupted frame must leave the variable at zero
    run(8'h2D, 8'h09, 8'h1B, 32'h11, 8'h01, 1'b1);
    run(8'h2D, 8'h0B, 8'h1B, 32'h5, 8'h64);
    check("var below imm", {30'h0, flags_out.greater, flags_out.lower}, 32'h1);
  endtask : t_var_imm

  task automatic t_xreg_ops;
    logic [31:0] ex [12] = '{32'h6B, 32'h5D, 32'h2BC, 32'hE, 32'h2, 32'h4, 32'h67, 32'h63,
                             32'hFFFF_FFF8, 32'h7, 32'h64, 32'h7};
    run(8'h2D, 8'h09, 8'h01, 32'h64, 8'h64);
    run(8'h2D, 8'h09, 8'h03, 32'h7, 8'h64);
    // Swap runs last since it rewrites the operand
    for (int i = 0; i < 12; i++)
    begin
      run(8'h2C, 8'h09, 8'h01, 32'h0, 8'h64);
      run(8'h2C, i < 10 ? i[7:0] : 8'h15 - i[7:0], 8'h03, 32'h0, 8'h64);
      check("x result", xreg_out, ex[i]);
    end
    check("x above var", {30'h0, flags_out.greater, flags_out.lower}, 32'h2);
    run(8'h2C, 8'h09, 8'h03, 32'h0, 8'h64);
    check("swapped var", xreg_out, 32'h64);
  endtask : t_xreg_ops

  task automatic t_restart;
    run(8'h30, 8'h00, 8'h00, 32'hA, 8'h02);
    check("idle restart", n_rst, 32'h0);
    standalone_in = 1'b1;
    run(8'h30, 8'h00, 8'h00, 32'hA, 8'h64);
    check("restart pulses", {n_rst[15:0], n_load[15:0]}, 32'h0001_0001);
    check("restart target", last_pc, 32'hA);
    check("restart reply", rval, 32'hA);
    check("x cleared", xreg_out, 32'h0);
  endtask : t_restart

  task automatic t_loop;
    i_cli_host_model.slow = 1'b1;
    run(8'h2D, 8'h09, 8'h2A, 32'h2, 8'h64);
    run(8'h31, 8'h2A, 8'h00, 32'h1, 8'h64);
    check("branch taken", last_pc, 32'h1);
    run(8'h31, 8'h2A, 8'h5A, 32'h1, 8'h64);
    check("fall through", {n_load[15:0], last_pc[15:0]}, 32'h0003_0055);
    run(8'h2C, 8'h09, 8'h2A, 32'h0, 8'h64);
    check("counter spent", xreg_out, 32'h0);
    check("zero flags", {28'h0, flags_out}, 32'hC);
  endtask : t_loop

  initial
  begin
    repeat (6) @(negedge clk_sys_in);
    rst_in = 1'b0;
    t_var_imm();
    t_xreg_ops();
    t_restart();
    t_loop();
    give_verdict();
  end
endmodule : calc_and_loop_instruction_unit_tb

bind cli_unit cli_unit_assertions i_cli_unit_assertions (.clk_sys_in(clk_sys_in),
  .rst_in(rst_in), .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out),
  .rsp_valid_out(rsp_valid_out), .rsp_byte_out(rsp_byte_out), .rsp_ready_in(rsp_ready_in),
  .standalone_in(standalone_in), .pc_load_out(pc_load_out),
  .interp_reset_out(interp_reset_out), .xreg_out(xreg_out), .flags_out(flags_out));
`default_nettype wire

// >>> verif/cli_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module cli_host_model (
  // Clock
  input  wire logic       clk_sys_in,
  // Command stream
  output var logic        cmd_valid_out,
  output var logic [7:0]  cmd_byte_out,
  input  wire logic       ready_in,
  // Reply stream
  input  wire logic       rsp_valid_in,
  input  wire logic [7:0] rsp_byte_in,
  output var logic        rsp_ready_out
);
  logic [7:0] rsp_q [9];
  logic       slow;

  initial
  begin
    cmd_valid_out = 1'b0;
    cmd_byte_out  = 8'h00;
    rsp_ready_out = 1'b0;
    slow          = 1'b0;
  end

  task automatic put(input logic [7:0] b);
    @(negedge clk_sys_in);
    cmd_valid_out = 1'b1;
    cmd_byte_out  = b;
    while (!ready_in) @(negedge clk_sys_in);
  endtask : put

  task automatic frame(input logic [7:0] op, typ, bank, input logic [31:0] val,
                       input logic bad);
    logic [7:0] f [9];
    f = '{8'h01, op, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
    for (int i = 0; i < 8; i++) f[8] += f[i];
    f[8] += {7'h00, bad};
    for (int i = 0; i < 9; i++) put(f[i]);
    @(negedge clk_sys_in);
    cmd_valid_out = 1'b0;
    // Released line must not keep showing the last byte
    cmd_byte_out  = ~cmd_byte_out;
    rsp_ready_out = !slow;
    for (int i = 0; i < 9; i++)
    begin
      if (slow)
      begin
        repeat (2) @(negedge clk_sys_in);
        rsp_ready_out = 1'b1;
      end
      while (!rsp_valid_in) @(negedge clk_sys_in);
      rsp_q[i] = rsp_byte_in;
      @(negedge clk_sys_in);
      if (slow)
        rsp_ready_out = 1'b0;
    end
  endtask : frame
endmodule : cli_host_model
`default_nettype wire

// >>> verif/cli_unit_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module cli_unit_assertions
  import cli_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  // Streams
  input wire logic        cmd_valid_in,
  input wire logic        cmd_ready_out,
  input wire logic        rsp_valid_out,
  input wire logic [7:0]  rsp_byte_out,
  input wire logic        rsp_ready_in,
  // Sequencer side
  input wire logic        standalone_in,
  input wire logic        pc_load_out,
  input wire logic        interp_reset_out,
  input wire logic [31:0] xreg_out,
  input wire cli_flags_t  flags_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  // Byte position inside the current command frame
  logic [3:0] n_q;
  always_ff @(posedge clk_sys_in or posedge rst_in)
    if (rst_in)
      n_q <= 4'h0;
    else if (cmd_valid_in && cmd_ready_out)
      n_q <= (n_q == 4'h8) ? 4'h0 : n_q + 4'h1;

  frame_close_a: assert property (cmd_valid_in && cmd_ready_out && n_q == 4'h8 |=>
    !cmd_ready_out ##[1:60] rsp_valid_out) else $error("reply missing after frame");
  reply_head_a: assert property ($rose(rsp_valid_out) |-> rsp_byte_out == 8'h02)
    else $error("reply does not open with host address");
  reply_hold_a: assert property (rsp_valid_out && !rsp_ready_in |=>
    rsp_valid_out && $stable(rsp_byte_out)) else $error("reply byte dropped");
  busy_block_a: assert property (rsp_valid_out |-> !cmd_ready_out)
    else $error("command taken while replying");
  load_pulse_a: assert property (pc_load_out |=> !pc_load_out)
    else $error("pc load longer than one cycle");
  restart_load_a: assert property (interp_reset_out |-> ##[0:2] pc_load_out)
    else $error("restart without pc load");
  program_only_a: assert property (pc_load_out || interp_reset_out |-> standalone_in)
    else $error("sequencer touched outside program mode");
  flag_sane_a: assert property (!(flags_out.greater && flags_out.lower) &&
    !(flags_out.equal && (flags_out.greater || flags_out.lower))) else $error("flags clash");
  xreg_quiet_a: assert property (cmd_ready_out && !cmd_valid_in |=> $stable(xreg_out))
    else $error("x register moved while idle");
endmodule : cli_unit_assertions
`default_nettype wire
